// [supervision_map.vh]
`ifndef SUPERVISION_MAP_VH
`define SUPERVISION_MAP_VH

// Timing at 100 MHz
`define CLK_HZ          100000000
`define SELFTEST_MS     5000
`define HOLD_MS         2000
`define MS_CYCLES       (`CLK_HZ / 1000)

// Views, index order
`define VIEW_WEIGHT     3'h0
`define VIEW_ZERO       3'h1
`define VIEW_AOUT       3'h2
`define VIEW_LEVELS     3'h3
`define VIEW_INPUT      3'h4
`define VIEW_IDENT      3'h5
`define VIEW_COUNT      6

// Relay source codes
`define RSRC_INPROC     2'h0
`define RSRC_ABOVE      2'h1
`define RSRC_BELOW      2'h2

// Analogue output modes
`define AMODE_RANGE     2'h0
`define AMODE_CAP       2'h1
`define AMODE_FIXED     2'h2

// Register offsets
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_CAL_ZERO    4'h2
`define REG_TMP_ZERO    4'h3
`define REG_AOUT        4'h4
`define REG_LVL1        4'h5
`define REG_HYS1        4'h6
`define REG_LVL2        4'h7
`define REG_HYS2        4'h8
`define REG_ALOW        4'h9
`define REG_AHIGH       4'hA
`define REG_CAP         4'hB
`define REG_AFIX        4'hC
`define REG_ZERO_CMD    4'hD

// Control register fields
`define CTRL_AUTO       0
`define CTRL_ZERO_EN    1
`define CTRL_VIEW_LSB   2
`define CTRL_SRC1       7
`define CTRL_SRC2       8
`define CTRL_R1_LSB     9
`define CTRL_R2_LSB     11
`define CTRL_AMODE_LSB  13
`define CTRL_RESET      32'h0000_0021
`endif

// [level_channel.v]
`timescale 1ns/100ps
`include "supervision_map.vh"
module level_channel #(
    parameter W = 24
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         srst,
    // Settings
    input  wire         src_sel,
    input  wire [W-1:0] level,
    input  wire [W-1:0] hyst,
    // Signals
    input  wire [W-1:0] raw_in,
    input  wire [W-1:0] weight_in,
    // Status
    output reg          above_q
);
    wire signed [W:0] sig = src_sel ? {weight_in[W-1], weight_in}
                                    : {raw_in[W-1], raw_in};
    wire signed [W:0] lv  = {level[W-1], level};
    wire signed [W:0] hy  = {hyst[W-1], hyst};
    wire signed [W:0] lo  = hy[W] ? lv + hy : lv;
    wire signed [W:0] hi  = hy[W] ? lv : lv + hy;

    always @(posedge core_clk) begin
        if (srst) begin
            above_q <= 1'b0;
        end else if (sig > hi) begin
            above_q <= 1'b1;
        end else if (sig < lo) begin
            above_q <= 1'b0;
        end
    end
endmodule // level_channel

// [level_supervision_startup_control.v]
`timescale 1ns/100ps
`include "supervision_map.vh"
module level_supervision_startup_control #(
    parameter W           = 24,
    parameter SELFTEST_CY = `SELFTEST_MS * `MS_CYCLES,
    parameter HOLD_CY     = `HOLD_MS * `MS_CYCLES
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         srst,
    // Self-test
    input  wire         selftest_done,
    input  wire         selftest_fail,
    input  wire         instr_error,
    // Panel keys, levels
    input  wire         key_confirm,
    input  wire         key_dec,
    input  wire         key_inc,
    input  wire         key_setup,
    input  wire         setup_exit,
    // Serial
    input  wire         zero_cmd,
    // Measurement
    input  wire [W-1:0] raw_ana,
    input  wire [W-1:0] raw_dig,
    input  wire [W-1:0] wt_ana,
    input  wire [W-1:0] wt_dig,
    input  wire         ana_bw_higher,
    // Register port
    input  wire [3:0]   reg_addr,
    input  wire [31:0]  reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    output reg  [31:0]  reg_rdata,
    // Display and outputs
    output reg          show_ident,
    output reg          show_error,
    output reg          show_prompt,
    output reg          operating,
    output reg  [2:0]   view_q,
    output reg          quick_setup,
    output reg          normal_setup,
    output reg  [W-1:0] zero_offset,
    output reg  [W-1:0] aout_q,
    output reg          relay1,
    output reg          relay2,
    output reg          lvl1_above,
    output reg          lvl2_above
);
    localparam S_TEST = 6'b000001;
    localparam S_ERR  = 6'b000010;
    localparam S_WAIT = 6'b000100;
    localparam S_OPER = 6'b001000;
    localparam S_QSET = 6'b010000;
    localparam S_NSET = 6'b100000;

    reg [5:0]   st_q;
    reg [31:0]  tmr_q;
    reg [31:0]  hold_q;
    reg [31:0]  ctrl_q;
    reg [W-1:0] cal_zero_q;
    reg [W-1:0] tmp_zero_q;
    reg         tmp_valid_q;
    reg [W-1:0] lvl1_q, hys1_q, lvl2_q, hys2_q;
    reg [W-1:0] alow_q, ahigh_q, cap_q, afix_q;
    reg         conf_d1, dec_d1, inc_d1;
    reg [2:0]   nxt;

    wire in_setup = st_q[4] | st_q[5];
    wire conf_p   = key_confirm & ~conf_d1;
    wire dec_p    = key_dec & ~dec_d1;
    wire inc_p    = key_inc & ~inc_d1;

    // Higher-bandwidth filtered signals for supervision
    wire [W-1:0] raw_s = ana_bw_higher ? raw_ana : raw_dig;
    wire [W-1:0] wt_s  = ana_bw_higher ? wt_ana : wt_dig;
    wire [W-1:0] wt_ao = wt_ana;

    wire ch1_above, ch2_above;

    // Two supervision channels
    level_channel #(.W(W)) u_ch1 (
        .core_clk  (core_clk),
        .srst      (srst),
        .src_sel   (ctrl_q[`CTRL_SRC1]),
        .level     (lvl1_q),
        .hyst      (hys1_q),
        .raw_in    (raw_s),
        .weight_in (wt_s),
        .above_q   (ch1_above)
    );
    level_channel #(.W(W)) u_ch2 (
        .core_clk  (core_clk),
        .srst      (srst),
        .src_sel   (ctrl_q[`CTRL_SRC2]),
        .level     (lvl2_q),
        .hyst      (hys2_q),
        .raw_in    (raw_s),
        .weight_in (wt_s),
        .above_q   (ch2_above)
    );

    // View enabled test
    function view_on;
        input [2:0]  v;
        input [31:0] c;
        begin
            case (v)
                `VIEW_WEIGHT: view_on = 1'b1;
                `VIEW_ZERO:   view_on = c[`CTRL_ZERO_EN];
                default:      view_on = c[`CTRL_VIEW_LSB + v - 3'h2];
            endcase
        end
    endfunction

    // Relay drive from source code
    function relay_drv;
        input [1:0] src;
        input       above;
        input       oper;
        begin
            case (src)
                `RSRC_INPROC: relay_drv = oper;
                `RSRC_ABOVE:  relay_drv = above;
                `RSRC_BELOW:  relay_drv = ~above;
                default:      relay_drv = 1'b0;
            endcase
        end
    endfunction

    // Next enabled view in either direction
    function [2:0] step_view;
        input [2:0]  v;
        input        up;
        input [31:0] c;
        integer      i;
        reg   [2:0]  t;
        reg          fnd;
        begin
            t   = v;
            fnd = 1'b0;
            step_view = v;
            for (i = 0; i < `VIEW_COUNT; i = i + 1) begin
                if (up) begin
                    t = (t == 3'h5) ? 3'h0 : t + 3'h1;
                end else begin
                    t = (t == 3'h0) ? 3'h5 : t - 3'h1;
                end
                if (!fnd && view_on(t, c)) begin
                    step_view = t;
                    fnd = 1'b1;
                end
            end
        end
    endfunction

    // Start-up and mode sequencer
    always @(posedge core_clk) begin
        if (srst) begin
            st_q    <= S_TEST;
            tmr_q   <= 32'h0000_0000;
            hold_q  <= 32'h0000_0000;
            view_q  <= `VIEW_WEIGHT;
            conf_d1 <= 1'b0;
            dec_d1  <= 1'b0;
            inc_d1  <= 1'b0;
        end else begin
            conf_d1 <= key_confirm;
            dec_d1  <= key_dec;
            inc_d1  <= key_inc;
            case (st_q)
                S_TEST: begin
                    if (selftest_fail) begin
                        st_q <= S_ERR;
                    end else if (tmr_q >= SELFTEST_CY - 1 &&
                                 selftest_done) begin
                        st_q <= ctrl_q[`CTRL_AUTO] ? S_OPER : S_WAIT;
                    end else if (tmr_q < SELFTEST_CY - 1) begin
                        tmr_q <= tmr_q + 32'h0000_0001;
                    end
                end
                S_ERR: st_q <= S_ERR;
                S_WAIT: begin
                    if (conf_p) begin
                        st_q <= S_OPER;
                    end
                end
                S_OPER: begin
                    if (key_setup) begin
                        if (hold_q >= HOLD_CY - 1) begin
                            st_q   <= key_inc ? S_NSET : S_QSET;
                            hold_q <= 32'h0000_0000;
                        end else begin
                            hold_q <= hold_q + 32'h0000_0001;
                        end
                    end else begin
                        hold_q <= 32'h0000_0000;
                        if (inc_p) begin
                            view_q <= nxt;
                        end else if (dec_p) begin
                            view_q <= nxt;
                        end
                    end
                end
                S_QSET, S_NSET: begin
                    if (setup_exit) begin
                        st_q   <= S_OPER;
                        view_q <= `VIEW_WEIGHT;
                    end
                end
                default: st_q <= S_TEST;
            endcase
        end
    end

    always @* begin
        nxt = step_view(view_q, inc_p, ctrl_q);
    end

    // Register writes and zero handling
    always @(posedge core_clk) begin
        if (srst) begin
            ctrl_q      <= `CTRL_RESET;
            cal_zero_q  <= {W{1'b0}};
            tmp_zero_q  <= {W{1'b0}};
            tmp_valid_q <= 1'b0;
            lvl1_q      <= {W{1'b0}};
            hys1_q      <= {W{1'b0}};
            lvl2_q      <= {W{1'b0}};
            hys2_q      <= {W{1'b0}};
            alow_q      <= {W{1'b0}};
            ahigh_q     <= {W{1'b1}};
            cap_q       <= {W{1'b1}};
            afix_q      <= {W{1'b0}};
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `REG_CTRL: ctrl_q <= reg_wdata;
                    `REG_CAL_ZERO: begin
                        if (in_setup) begin
                            cal_zero_q <= reg_wdata[W-1:0];
                        end
                    end
                    `REG_LVL1:  lvl1_q  <= reg_wdata[W-1:0];
                    `REG_HYS1:  hys1_q  <= reg_wdata[W-1:0];
                    `REG_LVL2:  lvl2_q  <= reg_wdata[W-1:0];
                    `REG_HYS2:  hys2_q  <= reg_wdata[W-1:0];
                    `REG_ALOW:  alow_q  <= reg_wdata[W-1:0];
                    `REG_AHIGH: ahigh_q <= reg_wdata[W-1:0];
                    `REG_CAP:   cap_q   <= reg_wdata[W-1:0];
                    `REG_AFIX:  afix_q  <= reg_wdata[W-1:0];
                    default: ;
                endcase
            end
            if (in_setup) begin
                tmp_valid_q <= 1'b0;
            end else if (st_q == S_OPER && ctrl_q[`CTRL_ZERO_EN] &&
                         view_q == `VIEW_ZERO && conf_p) begin
                tmp_zero_q  <= wt_s;
                tmp_valid_q <= 1'b1;
            end else if (zero_cmd || (reg_wr &&
                         reg_addr == `REG_ZERO_CMD)) begin
                tmp_zero_q  <= wt_s;
                tmp_valid_q <= 1'b1;
            end
        end
    end

    // Analogue output scaling, full scale as all ones
    function [W-1:0] scale;
        input [W-1:0] v;
        input [W-1:0] lo;
        input [W-1:0] hi;
        reg   [2*W-1:0] num;
        reg   [W-1:0]   span;
        begin
            span = hi - lo;
            if (v <= lo || span == {W{1'b0}}) begin
                scale = {W{1'b0}};
            end else if (v >= hi) begin
                scale = {W{1'b1}};
            end else begin
                num   = (v - lo) * {W{1'b1}};
                num   = num / {{W{1'b0}}, span};
                scale = num[W-1:0];
            end
        end
    endfunction

    // Output registers
    always @(posedge core_clk) begin
        if (srst) begin
            show_ident   <= 1'b1;
            show_error   <= 1'b0;
            show_prompt  <= 1'b0;
            operating    <= 1'b0;
            quick_setup  <= 1'b0;
            normal_setup <= 1'b0;
            zero_offset  <= {W{1'b0}};
            aout_q       <= {W{1'b0}};
            relay1       <= 1'b0;
            relay2       <= 1'b0;
            lvl1_above   <= 1'b0;
            lvl2_above   <= 1'b0;
        end else begin
            show_ident   <= st_q == S_TEST;
            show_error   <= st_q == S_ERR;
            show_prompt  <= st_q == S_WAIT;
            operating    <= st_q == S_OPER;
            quick_setup  <= st_q == S_QSET;
            normal_setup <= st_q == S_NSET;
            zero_offset  <= tmp_valid_q ? tmp_zero_q : cal_zero_q;
            lvl1_above   <= ch1_above;
            lvl2_above   <= ch2_above;
            if (instr_error || st_q == S_ERR) begin
                aout_q <= {W{1'b0}};
                relay1 <= 1'b0;
                relay2 <= 1'b0;
            end else begin
                case (ctrl_q[`CTRL_AMODE_LSB +: 2])
                    `AMODE_FIXED: aout_q <= afix_q;
                    `AMODE_CAP:
                        aout_q <= scale(wt_ao, {W{1'b0}}, cap_q);
                    default:
                        aout_q <= scale(wt_ao, alow_q, ahigh_q);
                endcase
                relay1 <= relay_drv(ctrl_q[`CTRL_R1_LSB +: 2],
                                    ch1_above, st_q == S_OPER);
                relay2 <= relay_drv(ctrl_q[`CTRL_R2_LSB +: 2],
                                    ch2_above, st_q == S_OPER);
            end
        end
    end

    // Register reads, data one cycle later
    always @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:     reg_rdata <= ctrl_q;
                `REG_STATUS:   reg_rdata <= {20'h0_0000, st_q, view_q,
                                             tmp_valid_q, ch2_above,
                                             ch1_above};
                `REG_CAL_ZERO: reg_rdata <= {{(32-W){1'b0}}, cal_zero_q};
                `REG_TMP_ZERO: reg_rdata <= {{(32-W){1'b0}}, tmp_zero_q};
                `REG_AOUT:     reg_rdata <= {{(32-W){1'b0}}, aout_q};
                `REG_LVL1:     reg_rdata <= {{(32-W){1'b0}}, lvl1_q};
                `REG_HYS1:     reg_rdata <= {{(32-W){1'b0}}, hys1_q};
                `REG_LVL2:     reg_rdata <= {{(32-W){1'b0}}, lvl2_q};
                `REG_HYS2:     reg_rdata <= {{(32-W){1'b0}}, hys2_q};
                default:       reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // level_supervision_startup_control

// [panel_model.sv]
`timescale 1ns/100ps
module panel_model (
    // Clock
    input  wire  core_clk,
    // Keys and serial command
    output logic key_confirm,
    output logic key_dec,
    output logic key_inc,
    output logic key_setup,
    output logic setup_exit,
    output logic zero_cmd
);
    initial {key_confirm, key_dec, key_inc, key_setup, setup_exit,
             zero_cmd} = '0;

    // Codes: 0 confirm, 1 dec, 2 inc, 3 setup, 4 setup and inc,
    // 5 leave set-up, 6 serial zero
    task press(input int code, input int n);
        @(posedge core_clk);
        key_confirm <= (code == 0);
        key_dec     <= (code == 1);
        key_inc     <= (code == 2 || code == 4);
        key_setup   <= (code == 3 || code == 4);
        setup_exit  <= (code == 5);
        zero_cmd    <= (code == 6);
        repeat (n) @(posedge core_clk);
        {key_confirm, key_dec, key_inc, key_setup, setup_exit,
         zero_cmd} <= '0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
endmodule // panel_model

// [supervision_checker.sv]
`timescale 1ns/100ps
module supervision_checker #(
    parameter W           = 24,
    parameter SELFTEST_CY = 50,
    parameter HOLD_CY     = 20
) (
    // Clock and reset
    input wire         core_clk,
    input wire         srst,
    // Inputs watched
    input wire         selftest_fail,
    input wire         instr_error,
    input wire         key_confirm,
    input wire         key_inc,
    input wire         key_setup,
    // Outputs watched
    input wire         show_ident,
    input wire         show_error,
    input wire         show_prompt,
    input wire         operating,
    input wire [2:0]   view_q,
    input wire         quick_setup,
    input wire         normal_setup,
    input wire [W-1:0] aout_q,
    input wire         relay1,
    input wire         relay2
);
    localparam int TC = SELFTEST_CY - 2;
    localparam int HC = HOLD_CY + 4;
    int   up_q, set_q, both_q;
    logic fail_q;

    // Cycles since reset and key hold counts
    always @(posedge core_clk) begin
        if (srst) begin
            up_q   <= 0;
            fail_q <= 1'b0;
        end else begin
            if (up_q < TC) up_q <= up_q + 1;
            if (selftest_fail) fail_q <= 1'b1;
        end
        if (srst || !key_setup || (set_q == 0 && !operating)) set_q <= 0;
        else if (set_q < HC) set_q <= set_q + 1;
        if (srst || !key_setup || !key_inc || (both_q == 0 && !operating))
            both_q <= 0;
        else if (both_q < HC) both_q <= both_q + 1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    ident_test_a: assert property (
        up_q < TC && !fail_q && !selftest_fail |-> show_ident && !operating)
        else $error("identity view left before self-test end");
    error_stuck_a: assert property (
        show_error |=> show_error && !operating)
        else $error("error state left");
    start_path_a: assert property (
        $rose(operating) |-> $past(show_ident) || $past(show_prompt)
            || $past(quick_setup) || $past(normal_setup))
        else $error("operating entered from wrong state");
    wait_hold_a: assert property (
        (!key_confirm)[*5] ##0 show_prompt |=> show_prompt)
        else $error("waiting state left without confirm");
    quick_hold_a: assert property (
        set_q == HC && both_q == 0 |-> quick_setup)
        else $error("quick set-up not entered");
    normal_hold_a: assert property (
        both_q == HC |-> normal_setup)
        else $error("normal set-up not entered");
    view_home_a: assert property (
        (quick_setup || normal_setup) ##1 operating |-> view_q == 3'h0)
        else $error("weight view not first after set-up");
    error_off_a: assert property (
        instr_error[*4] |-> !relay1 && !relay2 && aout_q == '0)
        else $error("outputs active during instrument error");

    cover property ($rose(operating));
    cover property (show_prompt ##1 operating);
    cover property ($rose(quick_setup));
    cover property ($rose(normal_setup));
    cover property ($rose(show_error));
endmodule // supervision_checker

bind level_supervision_startup_control supervision_checker #(
    .W(W), .SELFTEST_CY(SELFTEST_CY), .HOLD_CY(HOLD_CY)
) u_checker (
    .core_clk, .srst, .selftest_fail, .instr_error, .key_confirm,
    .key_inc, .key_setup, .show_ident, .show_error, .show_prompt,
    .operating, .view_q, .quick_setup, .normal_setup, .aout_q,
    .relay1, .relay2
);

// [tb.sv]
`timescale 1ns/100ps
module tb;
    localparam int W  = 24;
    localparam int ST = 50;
    localparam int HC = 20;
    // Stimulus
    logic         core_clk      = 1'b0;
    logic         srst          = 1'b1;
    logic         selftest_done = 1'b1;
    logic         selftest_fail = 1'b0;
    logic         instr_error   = 1'b0;
    logic         ana_bw_higher = 1'b1;
    logic [W-1:0] raw_ana = '0, raw_dig = '0, wt_ana = '0, wt_dig = '0;
    logic [3:0]   reg_addr      = 4'h0;
    logic [31:0]  reg_wdata     = 32'h0000_0000;
    logic         reg_wr        = 1'b0;
    logic         reg_rd        = 1'b0;
    // Panel and outputs
    wire          key_confirm, key_dec, key_inc, key_setup, setup_exit;
    wire          zero_cmd, show_ident, show_error, show_prompt, operating;
    wire          quick_setup, normal_setup, relay1, relay2;
    wire          lvl1_above, lvl2_above;
    wire [31:0]   reg_rdata;
    wire [2:0]    view_q;
    wire [W-1:0]  zero_offset, aout_q;
    int           err_count = 0, n_compared = 0, cyc = 0;

    panel_model u_panel (.core_clk, .key_confirm, .key_dec, .key_inc,
        .key_setup, .setup_exit, .zero_cmd);
    level_supervision_startup_control #(.W(W), .SELFTEST_CY(ST),
        .HOLD_CY(HC)) u_dut (.core_clk, .srst, .selftest_done,
        .selftest_fail, .instr_error, .key_confirm, .key_dec, .key_inc,
        .key_setup, .setup_exit, .zero_cmd, .raw_ana, .raw_dig, .wt_ana,
        .wt_dig, .ana_bw_higher, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .show_ident, .show_error, .show_prompt, .operating,
        .view_q, .quick_setup, .normal_setup, .zero_offset, .aout_q,
        .relay1, .relay2, .lvl1_above, .lvl2_above);

    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    task stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr(logic [3:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task rd(logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task pause(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task reset_dut();
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        pause(1);
    endtask

    task set_weight(int w);
        @(posedge core_clk);
        wt_ana <= W'(w);
        wt_dig <= W'(w);
        pause(5);
    endtask

    function automatic int next_view(int v, bit up, logic [31:0] m);
        do v = up ? (v + 1) % 6 : (v + 5) % 6;
        while (v != 0 && !m[v]);
        return v;
    endfunction

    function automatic int hyst(int a, int s, int lo, int hi);
        return s > hi ? 1 : (s < lo ? 0 : a);
    endfunction

    initial begin
        logic [31:0] d, m;
        int n, v, e, c, lv, hy, a1, a2;
        int q[4];
        void'($urandom(32'hac50));
        reset_dut();
        chk("ident", show_ident, 1);
        for (n = 0; n < 500 && operating !== 1'b1; n++) pause(1);
        chk("startup_long", n >= ST - 3, 1);
        chk("auto_start", operating, 1);
        chk("first_view", view_q, 0);
        pause(3);
        chk("relay_inproc", relay1, 1);
        rd(4'hF, d);
        chk("unmapped", d, 0);
        $display("test startup done");
        e = 1 + $urandom % 5000;
        set_weight(e);
        chk("aout_live", aout_q, e);
        @(posedge core_clk);
        instr_error <= 1'b1;
        pause(5);
        chk("err_relays", {relay1, relay2}, 0);
        chk("err_aout", aout_q, 0);
        instr_error <= 1'b0;
        pause(4);
        chk("relay_back", relay1, 1);
        $display("test error done");
        m = $urandom & 32'h0000_003e;
        wr(4'h0, m | 1);
        v = 0;
        for (n = 0; n < 8 || v != 0; n++) begin
            e = (n % 3 == 2);
            u_panel.press(e ? 1 : 2, 2);
            v = next_view(v, !e, m);
            chk("view", view_q, v);
        end
        $display("test views done");
        wr(4'h0, 32'h0000_0003);
        u_panel.press(2, 2);
        e = $urandom % 5000;
        set_weight(e);
        u_panel.press(0, 2);
        chk("panel_zero", zero_offset, e);
        e = $urandom % 5000;
        set_weight(e);
        u_panel.press(6, 1);
        chk("serial_zero", zero_offset, e);
        e = $urandom % 5000;
        set_weight(e);
        wr(4'hD, 32'h0000_0000);
        rd(4'h3, d);
        chk("reg_zero", d, e);
        c = $urandom & 32'h00ff_ffff;
        wr(4'h2, c);
        rd(4'h2, d);
        chk("cal_locked", d, 0);
        u_panel.press(3, HC + 5);
        chk("quick", quick_setup, 1);
        chk("zero_dropped", zero_offset, 0);
        wr(4'h2, c);
        rd(4'h2, d);
        chk("cal_write", d, c);
        u_panel.press(5, 1);
        chk("setup_left", {operating, view_q}, 8);
        chk("cal_used", zero_offset, c);
        u_panel.press(4, HC + 5);
        chk("normal", normal_setup, 1);
        u_panel.press(5, 1);
        $display("test zero done");
        lv = 1000 + $urandom % 1000;
        hy = 50 + $urandom % 50;
        wr(4'h0, 32'h0000_1281);
        wr(4'h5, lv);
        wr(4'h6, hy);
        wr(4'h7, lv);
        wr(4'h8, (-hy) & 32'h00ff_ffff);
        for (n = 0; n < 24; n++) begin
            foreach (q[i]) q[i] = n == 0 ? lv - 300 : lv - 150 + $urandom % 300;
            e = $urandom % 2;
            @(posedge core_clk);
            {raw_ana, raw_dig, wt_ana, wt_dig} <= {W'(q[0]), W'(q[1]),
                                                   W'(q[2]), W'(q[3])};
            ana_bw_higher <= e[0];
            a1 = hyst(a1, e ? q[2] : q[3], lv, lv + hy);
            a2 = hyst(a2, e ? q[0] : q[1], lv - hy, lv);
            pause(5);
            chk("lvl1", lvl1_above, a1);
            chk("lvl2", lvl2_above, a2);
            chk("relay_above", relay1, a1);
            chk("relay_below", relay2, !a2);
            rd(4'h1, d);
            chk("status", d[1:0], {a2[0], a1[0]});
        end
        $display("test levels done");
        e = $urandom & 32'h00ff_ffff;
        wr(4'hC, e);
        wr(4'h0, 32'h0000_4001);
        pause(4);
        chk("fixed_out", aout_q, e);
        wr(4'h9, lv);
        wr(4'hA, lv + 1000);
        wr(4'h0, 32'h0000_0001);
        set_weight(lv);
        chk("range_low", aout_q, 0);
        set_weight(lv + 500);
        chk("range_mid", aout_q, 32'h007f_ffff);
        set_weight(lv + 1000);
        chk("range_high", aout_q, 32'h00ff_ffff);
        wr(4'hB, 1000);
        wr(4'h0, 32'h0000_2001);
        set_weight(1000);
        chk("capacity", aout_q, 32'h00ff_ffff);
        $display("test output done");
        selftest_done <= 1'b0;
        reset_dut();
        wr(4'h0, 32'h0000_0020);
        pause(ST + 10);
        chk("tests_pending", show_ident, 1);
        selftest_done <= 1'b1;
        pause(3);
        chk("prompt", show_prompt, 1);
        pause(10);
        chk("prompt_held", show_prompt, 1);
        u_panel.press(0, 2);
        chk("confirmed", {operating, view_q}, 8);
        $display("test operator start done");
        selftest_fail <= 1'b1;
        reset_dut();
        pause(ST + 10);
        chk("fail", {show_error, operating}, 2);
        selftest_fail <= 1'b0;
        pause(10);
        chk("fail_held", {show_error, operating}, 2);
        $display("test self-test failure done");
        stop_test();
    end
endmodule // tb
